// [hw/sp_consts.svh]
// Register addresses, bit positions, reset values and timing counts of the serial port.
`ifndef SP_CONSTS_SVH
`define SP_CONSTS_SVH
`define SP_SERIAL_CONTROL_STATUS_ADDR 8'h98
`define SP_SERIAL_BUFFER_REG_ADDR 8'h99
`define SP_SERIAL_CONTROL_STATUS_RESET 8'h00
`define SP_BIT_FE 7
`define SP_BIT_TI 1
`define SP_BIT_RI 0
`define SP_M0_BIT_CLKS 12
`define SP_M0_HALF (`SP_M0_BIT_CLKS / 2)
`define SP_OVERSAMPLE 16
`define SP_M2_TICK_SLOW (64 / `SP_OVERSAMPLE)
`define SP_M2_TICK_FAST (32 / `SP_OVERSAMPLE)
`define SP_RX_MID (`SP_OVERSAMPLE / 2)
`define SP_STATE_TIME_CLKS 2
`define SP_BRG_SLOW_PRE 6
`endif

// [hw/sp_pkg.sv]
// Types shared by the serial port and its baud generator.
package sp_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } sp_sfr_req_t;

   typedef struct packed {
      logic mode2RateDouble;
      logic generatorRateDouble;
      logic bit7AliasSelect;
      logic txTimerBSelect;
      logic rxTimerBSelect;
      logic txInternalGenSelect;
      logic rxInternalGenSelect;
      logic fastDividerSelect;
      logic mode0GeneratorSelect;
      logic generatorRun;
      logic [7:0] generatorReloadValue;
      logic [15:0] timerBReload;
   } sp_cfg_t;

   typedef struct packed {
      logic modeSelectHi;
      logic modeSelectLo;
      logic multiprocEnable;
      logic receiveEnable;
      logic txNinthBit;
      logic rxNinthBit;
      logic transmitDoneFlag;
      logic receiveInterruptFlag;
   } sp_serial_control_status_t;

   typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100} sp_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_SHIFT = 2'b10} sp_rx_state_t;

   typedef struct packed {
      sp_serial_control_status_t serial_control_status;
      logic framingErrorFlag;
      logic [7:0] rxBuf;
      logic [7:0] rdata;
      sp_tx_state_t txState;
      logic [10:0] txShift;
      logic [3:0] txCnt;
      logic [3:0] txDiv;
      logic txHalf;
      sp_rx_state_t rxState;
      logic [7:0] rxData;
      logic rxNinth;
      logic [3:0] rxCnt;
      logic [3:0] rxDiv;
      logic rxHalf;
      logic rxS1;
      logic rxS2;
      logic rxS3;
      logic [1:0] m2Cnt;
      logic [2:0] m0Cnt;
      logic m0Phase;
      logic txd;
      logic rxdOut;
      logic rxdOe;
   } sp_port_st_t;

   typedef struct packed {
      logic [15:0] t2Cnt;
      logic t2Phase;
      logic t2Ovf;
      logic [2:0] preCnt;
      logic [7:0] brgCnt;
      logic brgOvf;
   } sp_gen_st_t;
endpackage

// [hw/sp_baud_gen.sv]
// Timer 2 baud mode and internal reload baud generator, each giving one-cycle overflow pulses.
`timescale 1ns/100ps
`include "sp_consts.svh"
module sp_baud_gen import sp_pkg::*; #(
   parameter int PRESCALE = `SP_BRG_SLOW_PRE
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Configuration.
   input wire sp_cfg_t cfg,
   // Overflow pulses.
   output logic brgOvf,
   output logic t2Ovf
);
   sp_gen_st_t q, d;

   if (PRESCALE < 1 || PRESCALE > 7) begin : g_chk
      $error("sp_baud_gen: PRESCALE must be 1 to 7");
   end

   always_comb begin
      d = q;
      d.t2Ovf = 1'b0;
      d.brgOvf = 1'b0;
      // Timer 2 steps once per state time and reloads silently on rollover.
      if (cfg.txTimerBSelect || cfg.rxTimerBSelect) begin
         d.t2Phase = !q.t2Phase;
         if (q.t2Phase) begin
            if (q.t2Cnt == 16'hffff) begin
               d.t2Cnt = cfg.timerBReload;
               d.t2Ovf = 1'b1;
            end else begin
               d.t2Cnt = q.t2Cnt + 16'h0001;
            end
         end
      end
      // The slow speed inserts a fixed prescaler ahead of the 8-bit reload counter.
      if (cfg.generatorRun) begin
         if (cfg.fastDividerSelect || q.preCnt == 3'(PRESCALE - 1)) begin
            d.preCnt = 3'h0;
            if (q.brgCnt == 8'hff) begin
               d.brgCnt = cfg.generatorReloadValue;
               d.brgOvf = 1'b1;
            end else begin
               d.brgCnt = q.brgCnt + 8'h01;
            end
         end else begin
            d.preCnt = q.preCnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign brgOvf = q.brgOvf;
   assign t2Ovf = q.t2Ovf;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_t2Reload;
      q.t2Ovf |-> q.t2Cnt == $past(cfg.timerBReload) && $past(q.t2Phase);
   endproperty
   a_t2Reload: assert property (p_t2Reload) else $error("timer 2 overflow without reload");

   property p_brgReload;
      q.brgOvf |-> q.brgCnt == $past(cfg.generatorReloadValue) && $past(q.brgCnt) == 8'hff;
   endproperty
   a_brgReload: assert property (p_brgReload) else $error("generator overflow wrong");
endmodule // sp_baud_gen

// [hw/sp_serial_port.sv]
// Serial port: shift-register mode and three UART modes behind control and buffer registers.
// ============================================================================
// Operation
// - Async transmitter and receiver run independently; in modes 1 and 3 each at its own baud rate, in mode 2 both at the mode 2 rate.
// - Receiver shifts a new byte while the old is unread; one is lost.
// - One buffer address: writes load transmit, reads return separate receive register.
// - Mode 0: data on receive pin, shift clock on transmit pin, 8 bits LSB first.
// - Mode 1: start, eight data LSB first, stop; stop goes to receive ninth bit.
// - Modes 2/3: start, eight data, transmit ninth bit, stop; stop only checked for framing error on receive.
// - Mode 2 rate is oscillator over 64, or over 32 when doubled.
// - Mode 3 equals mode 2 except its rate comes from selected source.
// - Mode 0 receives when flag clear, enabled and transmitter idle; others on start bit if enabled.
// - Alias select maps bit 7 to sticky framing error, cleared only by software.
// - Ninth bit received in modes 2/3, stop bit in mode 1, unused in mode 0.
// - Transmit flag sets after 8th bit in mode 0, at stop start otherwise.
// - Each direction picks internal generator, else timer 2, else timer 1.
// - Internal generator rate follows reload value, fast divider and rate doubling.
// - Internal generator clocks modes 1 and 3, and mode 0 when selected.
// - Async receive samples each bit once, on tick 8 of 16 per bit; falling edge resets divider.
// - Transmit frame starts only after next divide-by-16 rollover after a write.
// - Timer 2 baud mode counts every state time and reloads without flag.
`timescale 1ns/100ps
`include "sp_consts.svh"
module sp_serial_port import sp_pkg::*; #(
   parameter int M0_HALF = `SP_M0_HALF
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic reset,
   // Special function register access.
   input wire sp_sfr_req_t sfrReq,
   output logic [7:0] sfrRdata,
   // Configuration held in other registers and the timer 1 overflow pulse.
   input wire sp_cfg_t cfg,
   input wire logic timer1Ovf,
   // Serial pins.
   output logic txd,
   input wire logic rxdIn,
   output logic rxdOut,
   output logic rxdOe
);
   sp_port_st_t q, d;
   logic [1:0] mode;
   logic wrScon, wrBuf, m0Tick, m2Tick, txRaw, rxRaw, txTick, rxTick, txRoll, rxSample;
   logic txDbl, rxDbl, ninth;
   logic [3:0] txLast, rxLast;
   logic brgOvf, t2Ovf;

   if (M0_HALF < 1 || M0_HALF > 8) begin : g_chk
      $error("sp_serial_port: M0_HALF must be 1 to 8");
   end

   function automatic logic pick_src(input logic intSel, input logic t2Sel, input logic brg,
      input logic t2, input logic t1);
      pick_src = intSel ? brg : (t2Sel ? t2 : t1);
   endfunction

   // Timer 2 already runs at sixteen ticks per bit; the others halve unless doubled.
   function automatic logic src_double(input logic intSel, input logic t2Sel, input sp_cfg_t c);
      src_double = intSel ? c.generatorRateDouble : (t2Sel | c.mode2RateDouble);
   endfunction

   sp_baud_gen u_gen (
      .clock(clock),
      .reset(reset),
      .cfg(cfg),
      .brgOvf(brgOvf),
      .t2Ovf(t2Ovf)
   );

   always_comb begin
      d = q;
      mode = {q.serial_control_status.modeSelectHi, q.serial_control_status.modeSelectLo};
      wrScon = sfrReq.wr && sfrReq.addr == `SP_SERIAL_CONTROL_STATUS_ADDR;
      wrBuf = sfrReq.wr && sfrReq.addr == `SP_SERIAL_BUFFER_REG_ADDR;
      // =====================================================================
      // Bit clocks
      m0Tick = cfg.mode0GeneratorSelect ? brgOvf : (q.m0Cnt == 3'(M0_HALF - 1));
      d.m0Cnt = (q.m0Cnt == 3'(M0_HALF - 1)) ? 3'h0 : q.m0Cnt + 3'h1;
      if (m0Tick) d.m0Phase = !q.m0Phase;
      m2Tick = q.m2Cnt == (cfg.mode2RateDouble ? 2'(`SP_M2_TICK_FAST - 1)
         : 2'(`SP_M2_TICK_SLOW - 1));
      d.m2Cnt = m2Tick ? 2'h0 : q.m2Cnt + 2'h1;
      txRaw = pick_src(cfg.txInternalGenSelect, cfg.txTimerBSelect, brgOvf, t2Ovf, timer1Ovf);
      rxRaw = pick_src(cfg.rxInternalGenSelect, cfg.rxTimerBSelect, brgOvf, t2Ovf, timer1Ovf);
      txDbl = src_double(cfg.txInternalGenSelect, cfg.txTimerBSelect, cfg);
      rxDbl = src_double(cfg.rxInternalGenSelect, cfg.rxTimerBSelect, cfg);
      if (txRaw && !txDbl) d.txHalf = !q.txHalf;
      if (rxRaw && !rxDbl) d.rxHalf = !q.rxHalf;
      txTick = (mode == 2'b10) ? m2Tick : txRaw && (txDbl || q.txHalf);
      rxTick = (mode == 2'b10) ? m2Tick : rxRaw && (rxDbl || q.rxHalf);
      if (txTick) d.txDiv = q.txDiv + 4'h1;
      txRoll = txTick && q.txDiv == 4'hf;
      rxSample = rxTick && q.rxDiv == 4'(`SP_RX_MID - 1);
      txLast = (mode == 2'b01) ? 4'd9 : 4'd10;
      rxLast = txLast;
      ninth = (mode == 2'b01) ? q.rxS2 : q.rxNinth;
      // =====================================================================
      // Control register writes; hardware sets below override a clearing write.
      if (wrScon) begin
         d.serial_control_status = sp_serial_control_status_t'(sfrReq.wdata);
         if (cfg.bit7AliasSelect) begin
            d.serial_control_status.modeSelectHi = q.serial_control_status.modeSelectHi;
            d.framingErrorFlag = sfrReq.wdata[`SP_BIT_FE];
         end
      end
      // =====================================================================
      // Transmitter
      unique case (q.txState)
         TX_IDLE: begin
            if (wrBuf) begin
               d.txCnt = 4'h0;
               if (mode == 2'b00) begin
                  d.txShift = {3'b111, sfrReq.wdata};
                  d.txState = TX_WAIT;
               end else begin
                  d.txShift = {1'b1, (mode == 2'b01) | q.serial_control_status.txNinthBit, sfrReq.wdata, 1'b0};
                  d.txState = TX_WAIT;
               end
            end
         end
         TX_WAIT: begin
            if ((mode == 2'b00) ? (m0Tick && q.m0Phase) : txRoll) d.txState = TX_SEND;
         end
         TX_SEND: begin
            if (mode == 2'b00) begin
               if (m0Tick && q.m0Phase) begin
                  d.txShift = {1'b1, q.txShift[10:1]};
                  d.txCnt = q.txCnt + 4'h1;
                  if (q.txCnt == 4'd7) begin
                     d.serial_control_status.transmitDoneFlag = 1'b1;
                     d.txState = TX_IDLE;
                  end
               end
            end else if (txRoll) begin
               d.txShift = {1'b1, q.txShift[10:1]};
               d.txCnt = q.txCnt + 4'h1;
               if (q.txCnt + 4'h1 == txLast) d.serial_control_status.transmitDoneFlag = 1'b1;
               if (q.txCnt == txLast) d.txState = TX_IDLE;
            end
         end
      endcase
      // =====================================================================
      // Receiver
      d.rxS1 = rxdIn;
      d.rxS2 = q.rxS1;
      d.rxS3 = q.rxS2;
      unique case (q.rxState)
         RX_IDLE: begin
            if (mode == 2'b00) begin
               if (q.serial_control_status.receiveEnable && !q.serial_control_status.receiveInterruptFlag
                  && q.txState == TX_IDLE) begin
                  d.rxCnt = 4'h0;
                  d.rxState = RX_SHIFT;
               end
            end else if (q.serial_control_status.receiveEnable && q.rxS3 && !q.rxS2) begin
               d.rxDiv = 4'h0;
               d.rxCnt = 4'h0;
               d.rxState = RX_SHIFT;
            end
         end
         RX_SHIFT: begin
            if (mode == 2'b00) begin
               if (m0Tick && !q.m0Phase) begin
                  d.rxData = {q.rxS2, q.rxData[7:1]};
                  d.rxCnt = q.rxCnt + 4'h1;
                  if (q.rxCnt == 4'd7) begin
                     d.rxBuf = d.rxData;
                     d.serial_control_status.receiveInterruptFlag = 1'b1;
                     d.rxState = RX_IDLE;
                  end
               end
            end else begin
               if (rxTick) d.rxDiv = q.rxDiv + 4'h1;
               if (rxSample) begin
                  d.rxCnt = q.rxCnt + 4'h1;
                  if (q.rxCnt == 4'd0 && q.rxS2) d.rxState = RX_IDLE;
                  if (q.rxCnt >= 4'd1 && q.rxCnt <= 4'd8) d.rxData = {q.rxS2, q.rxData[7:1]};
                  if (q.rxCnt == 4'd9) d.rxNinth = q.rxS2;
                  if (q.rxCnt == rxLast) begin
                     d.rxState = RX_IDLE;
                     if (!q.rxS2) d.framingErrorFlag = 1'b1;
                     // A byte finishing while the flag is still set is dropped.
                     if (!q.serial_control_status.receiveInterruptFlag
                        && (!q.serial_control_status.multiprocEnable || ninth)) begin
                        d.rxBuf = q.rxData;
                        d.serial_control_status.rxNinthBit = ninth;
                        d.serial_control_status.receiveInterruptFlag = 1'b1;
                     end
                  end
               end
            end
         end
      endcase
      // =====================================================================
      // Pins and read data
      if (mode == 2'b00) begin
         d.txd = (d.txState == TX_SEND || d.rxState == RX_SHIFT) ? d.m0Phase : 1'b1;
      end else begin
         d.txd = (d.txState == TX_SEND) ? d.txShift[0] : 1'b1;
      end
      d.rxdOe = mode == 2'b00 && d.txState == TX_SEND;
      d.rxdOut = d.rxdOe ? d.txShift[0] : 1'b1;
      if (sfrReq.rd) begin
         if (sfrReq.addr == `SP_SERIAL_CONTROL_STATUS_ADDR) begin
            d.rdata = q.serial_control_status;
            if (cfg.bit7AliasSelect) d.rdata[`SP_BIT_FE] = q.framingErrorFlag;
         end else if (sfrReq.addr == `SP_SERIAL_BUFFER_REG_ADDR) begin
            d.rdata = q.rxBuf;
         end else begin
            d.rdata = 8'h00;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         q <= '0;
         q.serial_control_status <= `SP_SERIAL_CONTROL_STATUS_RESET;
         q.txState <= TX_IDLE;
         q.rxState <= RX_IDLE;
         q.rxS1 <= 1'b1;
         q.rxS2 <= 1'b1;
         q.rxS3 <= 1'b1;
         q.txd <= 1'b1;
         q.rxdOut <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign sfrRdata = q.rdata;
   assign txd = q.txd;
   assign rxdOut = q.rxdOut;
   assign rxdOe = q.rxdOe;

   // =========================================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   property p_txAlign;
      $rose(q.txState == TX_SEND) && $past(mode) != 2'b00 |-> $past(q.txDiv) == 4'hf;
   endproperty
   a_txAlign: assert property (p_txAlign) else $error("frame not aligned to rollover");

   property p_tiAtStop;
      $rose(q.serial_control_status.transmitDoneFlag) && $past(mode) != 2'b00 && !$past(wrScon)
         |-> q.txd && q.txState == TX_SEND;
   endproperty
   a_tiAtStop: assert property (p_tiAtStop) else $error("transmit flag not at stop bit");

   property p_m0Oe;
      q.rxdOe |-> $past(mode) == 2'b00 && q.txState == TX_SEND;
   endproperty
   a_m0Oe: assert property (p_m0Oe) else $error("data pin driven outside mode 0");

   property p_riLoad;
      $rose(q.serial_control_status.receiveInterruptFlag) && $past(mode) != 2'b00 && !$past(wrScon)
         |-> $past(q.rxState) == RX_SHIFT && $past(rxSample);
   endproperty
   a_riLoad: assert property (p_riLoad) else $error("receive flag without frame end");

   property p_feSticky;
      q.framingErrorFlag && !(wrScon && cfg.bit7AliasSelect) |=> q.framingErrorFlag;
   endproperty
   a_feSticky: assert property (p_feSticky) else $error("framing error lost");

   property p_renGate;
      q.rxState == RX_IDLE ##1 q.rxState == RX_SHIFT |-> $past(q.serial_control_status.receiveEnable);
   endproperty
   a_renGate: assert property (p_renGate) else $error("receive began while disabled");

   property p_m2Rate;
      disable iff (reset || cfg.mode2RateDouble)
      m2Tick |=> !m2Tick [*3] ##1 m2Tick;
   endproperty
   a_m2Rate: assert property (p_m2Rate) else $error("mode 2 tick spacing wrong");

   property p_bufRead;
      sfrReq.rd && sfrReq.addr == `SP_SERIAL_BUFFER_REG_ADDR |=> sfrRdata == $past(q.rxBuf);
   endproperty
   a_bufRead: assert property (p_bufRead) else $error("buffer read wrong");

   property p_rxEdge;
      q.rxState == RX_IDLE && mode != 2'b00 && q.serial_control_status.receiveEnable
         && q.rxS3 && !q.rxS2 |=> q.rxDiv == 4'h0 && q.rxState == RX_SHIFT;
   endproperty
   a_rxEdge: assert property (p_rxEdge) else $error("divider not reset on edge");

   property p_keepUnread;
      q.serial_control_status.receiveInterruptFlag |=> $stable(q.rxBuf);
   endproperty
   a_keepUnread: assert property (p_keepUnread) else $error("unread byte overwritten");
endmodule // sp_serial_port

// [verif/sp_remote_node.sv]
// Remote serial node: UART frames and a mode 0 shift partner on the port's pins.
`timescale 1ns/100ps
module sp_remote_node (
   // Clock.
   input wire logic clock,
   // Pins as seen from the far side.
   input wire logic txd,
   input wire logic line,
   output logic nodeLine
);
   // ==========================================================================
   // State
   int bitClks = 64;
   int recvClks = 64;
   int period = 0;
   logic hung = 1'b0;
   initial nodeLine = 1'b1;

   // ==========================================================================
   // Tasks
   // Every wait is bounded, so a silent port marks the node hung instead of stalling the run.
   task automatic waitTxd(input logic v);
      int t;
      t = 0;
      while (txd !== v && t < 4000) begin
         @(negedge clock);
         t++;
      end
      if (t == 4000) hung = 1'b1;
   endtask

   // Sends n bits LSB first, then returns the line to its driven idle high.
   task automatic sendFrame(input logic [10:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         nodeLine = bits[i];
         repeat (bitClks) @(negedge clock);
      end
      nodeLine = 1'b1;
   endtask

   // Samples each bit in its middle, counting from the detected start edge.
   task automatic recvFrame(input int n, output logic [10:0] bits);
      bits = 11'h000;
      waitTxd(1'b0);
      repeat (recvClks / 2) @(negedge clock);
      for (int i = 0; i < n; i++) begin
         bits[i] = txd;
         repeat (recvClks) @(negedge clock);
      end
   endtask

   // Captures the data line at each rising shift clock and times the clock period.
   task automatic shiftOut(output logic [7:0] d);
      time t0;
      t0 = 0;
      for (int i = 0; i < 8; i++) begin
         waitTxd(1'b0);
         waitTxd(1'b1);
         d[i] = line;
         period = int'(($time - t0) / 10);
         t0 = $time;
      end
   endtask

   // Presents each bit before the low half in which the port samples it.
   task automatic shiftIn(input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         nodeLine = d[i];
         waitTxd(1'b0);
         waitTxd(1'b1);
      end
      nodeLine = 1'b1;
   endtask
endmodule // sp_remote_node

// [verif/sp_serial_port_test.sv]
// Self-checking testbench of the serial port against a remote serial node.
`timescale 1ns/100ps
module sp_serial_port_test import sp_pkg::*;;
   // ==========================================================================
   // Signals
   logic clock = 1'b0;
   logic reset = 1'b1;
   sp_sfr_req_t sfrReq = '0;
   logic [7:0] sfrRdata;
   sp_cfg_t cfg = '0;
   logic timer1Ovf = 1'b0;
   logic txd;
   logic rxdOut;
   logic rxdOe;
   logic nodeLine;
   wire logic line;
   int fail_count = 0;
   int checked = 0;
   int seed = 44976;

   always #5 clock = ~clock;
   // The receive pin carries the port's data while it drives, else the node's.
   assign line = rxdOe ? rxdOut : nodeLine;
   // Timer 1 in auto-reload overflows every second clock, its interrupt unused.
   always @(negedge clock) timer1Ovf <= ~timer1Ovf;

   sp_serial_port i_sp_serial_port (.clock(clock), .reset(reset), .sfrReq(sfrReq),
      .sfrRdata(sfrRdata), .cfg(cfg), .timer1Ovf(timer1Ovf), .txd(txd), .rxdIn(line),
      .rxdOut(rxdOut), .rxdOe(rxdOe));
   sp_remote_node i_sp_remote_node (.clock(clock), .txd(txd), .line(line), .nodeLine(nodeLine));

   // ==========================================================================
   // Tasks
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfrReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(negedge clock);
      sfrReq.wr = 1'b0;
      @(negedge clock);
   endtask

   task automatic rdChk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      sfrReq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
      @(negedge clock);
      sfrReq.rd = 1'b0;
      @(negedge clock);
      chk(11'(sfrRdata & m), 11'(e));
   endtask

   function automatic logic [10:0] frame(input int m, input logic [7:0] d, input logic n9);
      return (m == 1) ? {2'b01, d, 1'b0} : {1'b1, n9, d, 1'b0};
   endfunction

   task automatic conclude();
      if (fail_count == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Transmit and receive at once in one async mode, then overrun the unread byte.
   task automatic asyncRun(input int m, input logic dbl);
      logic [7:0] dt;
      logic [7:0] dr;
      logic n9;
      logic [10:0] got;
      int n;
      dt = 8'($random(seed));
      dr = 8'($random(seed));
      n9 = 1'($random(seed));
      n = (m == 1) ? 10 : 11;
      cfg.mode2RateDouble = dbl;
      i_sp_remote_node.bitClks = dbl ? 32 : 64;
      i_sp_remote_node.recvClks = i_sp_remote_node.bitClks;
      wr(8'h98, {2'(m), 2'b01, n9, 3'b000});
      wr(8'h99, dt);
      fork
         i_sp_remote_node.recvFrame(n, got);
         i_sp_remote_node.sendFrame(frame(m, dr, ~n9), n);
      join
      chk(got, frame(m, dt, n9));
      rdChk(8'h98, 8'hff, {2'(m), 2'b01, n9, (m == 1) | ~n9, 2'b11});
      rdChk(8'h99, 8'hff, dr);
      i_sp_remote_node.sendFrame(frame(m, ~dr, n9), n);
      rdChk(8'h99, 8'hff, dr);
   endtask

   // Transmit on timer 1 and receive on the internal generator, each at its own rate.
   task automatic srcRun();
      logic [7:0] dt;
      logic [7:0] dr;
      logic [10:0] got;
      dt = 8'($random(seed));
      dr = 8'($random(seed));
      cfg = '{rxInternalGenSelect: 1'b1, generatorRun: 1'b1, fastDividerSelect: 1'b1,
         generatorRateDouble: 1'b1, generatorReloadValue: 8'hfe, default: '0};
      i_sp_remote_node.recvClks = 64;
      i_sp_remote_node.bitClks = 32;
      // The generator counts up from zero once before its first reload.
      repeat (300) @(negedge clock);
      wr(8'h98, 8'h50);
      wr(8'h99, dt);
      fork
         i_sp_remote_node.recvFrame(10, got);
         i_sp_remote_node.sendFrame(frame(1, dr, 1'b0), 10);
      join
      chk(got, frame(1, dt, 1'b0));
      rdChk(8'h98, 8'hff, 8'h57);
      rdChk(8'h99, 8'hff, dr);
   endtask

   task automatic mode0Run();
      logic [7:0] d;
      logic [7:0] got;
      d = 8'($random(seed));
      wr(8'h99, d);
      i_sp_remote_node.shiftOut(got);
      chk(11'(got), 11'(d));
      chk(11'(i_sp_remote_node.period), 11'h00c);
      repeat (12) @(negedge clock);
      rdChk(8'h98, 8'h03, 8'h02);
      d = 8'($random(seed));
      fork
         i_sp_remote_node.shiftIn(d);
         wr(8'h98, 8'h10);
      join
      repeat (12) @(negedge clock);
      rdChk(8'h98, 8'hff, 8'h11);
      rdChk(8'h99, 8'hff, d);
   endtask

   // ==========================================================================
   // Sequence
   initial begin
      repeat (10) @(negedge clock);
      reset = 1'b0;
      chk({9'h000, txd, rxdOe}, 11'h002);
      rdChk(8'h98, 8'hff, 8'h00);
      rdChk(8'h9a, 8'hff, 8'h00);
      mode0Run();
      for (int i = 0; i < 6; i++) asyncRun(1 + i % 3, 1'(i / 3));
      srcRun();
      cfg = '0;
      i_sp_remote_node.bitClks = 64;
      wr(8'h98, 8'h40);
      i_sp_remote_node.sendFrame(frame(1, 8'h3c, 1'b0), 10);
      rdChk(8'h98, 8'h01, 8'h00);
      wr(8'h98, 8'h50);
      cfg.bit7AliasSelect = 1'b1;
      // A zero stop bit raises the sticky error that a good frame must not clear.
      i_sp_remote_node.sendFrame(11'h0b4, 10);
      rdChk(8'h98, 8'h80, 8'h80);
      wr(8'h98, 8'hd0);
      i_sp_remote_node.sendFrame(frame(1, 8'ha5, 1'b0), 10);
      rdChk(8'h98, 8'hff, 8'hd5);
      rdChk(8'h99, 8'hff, 8'ha5);
      wr(8'h98, 8'h50);
      rdChk(8'h98, 8'hff, 8'h50);
      chk(11'(i_sp_remote_node.hung), 11'h000);
      conclude();
   end
endmodule // sp_serial_port_test
